// File: rtl/pcr_pkg.sv
// Package: constants and carrier types for the synchronous peripheral cycle block
package pcr_pkg;

   // ==========================================================
   // Enable clock divider
   localparam int unsigned PCR_E_LOW_CLKS = 6;   // Clocks with enable clock low
   localparam int unsigned PCR_E_HIGH_CLKS = 4;  // Clocks with enable clock high
   localparam int unsigned PCR_E_PERIOD = PCR_E_LOW_CLKS + PCR_E_HIGH_CLKS;
   localparam logic [3:0] PCR_E_CNT_RESET = 4'h0;
   // Latest divider count at which a recognised request still meets this period
   localparam logic [3:0] PCR_E_LATEST_REC = 4'h4;
   // Count of the clock that precedes the latch state
   localparam logic [3:0] PCR_E_PRE_LATCH = 4'h8;

   // ==========================================================
   // Autovector numbering
   localparam logic [7:0] PCR_AUTOVEC_BASE = 8'h18;  // Level n maps to base + n
   localparam logic [2:0] PCR_LEVEL_NMI = 3'h7;

   // ==========================================================
   // Widths and reset values
   localparam int unsigned PCR_ADDR_W = 23;
   localparam int unsigned PCR_DATA_W = 16;
   localparam int unsigned PCR_SYNC_STAGES = 2;
   localparam logic [15:0] PCR_DATA_RESET = 16'h0000;

   // ==========================================================
   // Bus states, gray coded along the wait path from idle to the end state
   typedef enum logic [2:0] {
      PCR_IDLE = 3'b000,
      PCR_S01  = 3'b001,
      PCR_S23  = 3'b011,
      PCR_S45  = 3'b010,
      PCR_SWT  = 3'b110,
      PCR_S67  = 3'b111,
      PCR_SEND = 3'b101
   } pcr_state_t;

   // Request from the processor core
   typedef struct packed {
      logic write;
      logic iack;
      logic [2:0] level;
      logic [PCR_ADDR_W-1:0] addr;
      logic [PCR_DATA_W-1:0] wdata;
      logic [1:0] strobes;
   } pcr_req_t;

   // Pin inputs from the peripheral side, low active controls
   typedef struct packed {
      logic cycle_request_n;
      logic ack_n;
      logic fault_n;
      logic [PCR_DATA_W-1:0] data;
   } pcr_pins_t;

   localparam int unsigned PCR_PINS_W = $bits(pcr_pins_t);
   localparam pcr_pins_t PCR_PINS_IDLE = '{
      cycle_request_n: 1'b1, ack_n: 1'b1, fault_n: 1'b1, data: PCR_DATA_RESET};

endpackage : pcr_pkg

// File: rtl/pcr_link_front.sv
// Link-side input register, clocked by the peripheral select logic clock
`timescale 1ns/1ps
module pcr_link_front
   import pcr_pkg::*;
(
   // Link clock and reset
   input wire logic link_clk,
   input wire logic resetn,
   // Pins from the peripheral side
   input wire pcr_pins_t pins_in,
   // Registered pins, still in the link domain
   output pcr_pins_t pins_link
);

   // ==========================================================
   // Capture on the link clock
   // Launching from one flop keeps the crossing free of glitches
   always_ff @(posedge link_clk or negedge resetn) begin
      if (!resetn) begin
         pins_link <= PCR_PINS_IDLE;
      end else begin
         pins_link <= pins_in;
      end
   end

endmodule : pcr_link_front

// File: rtl/pcr_sync.sv
// Two flip-flop level synchroniser, one chain per bit
`timescale 1ns/1ps
module pcr_sync
   import pcr_pkg::*;
#(
   parameter int unsigned WIDTH = 8,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   // Clock, reset and enable of the destination domain
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   // Levels from the other domain
   input wire logic [WIDTH-1:0] async_in,
   // Levels usable in this domain
   output logic [WIDTH-1:0] sync_out
);

   // ==========================================================
   // Synchroniser chains
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         logic meta_reg;
         // First stage feeds only the second stage
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               meta_reg <= RESET_VALUE[g];
               sync_out[g] <= RESET_VALUE[g];
            end else if (ce) begin
               meta_reg <= async_in[g];
               sync_out[g] <= meta_reg;
            end
         end
      end
   endgenerate

endmodule : pcr_sync

// File: rtl/pcr_bus_engine.sv
// Bus cycle engine: synchronous peripheral cycles, enable clock and autovectors
//
// Behaviour
// - A request for a peripheral cycle seen in state four turns the cycle into a peripheral cycle.
// - With no termination and no peripheral request by the end of state four, whole-clock waits follow.
// - After the peripheral request the engine waits for the enable clock low, then asserts address valid.
// - A prompt peripheral request is taken at the end of state four and only alignment waits are added.
// - Alignment is whole clocks; at best recognition is three clocks before the enable clock rises.
// - At worst recognition is two clocks before the enable clock rises, four after it falls.
// - On a peripheral read the data bus is latched in state six.
// - Strobes are released in state seven, together with the enable clock falling.
// - One clock after the strobes rise the address bus floats and read/write goes high.
// - Acknowledge marks an asynchronous cycle, the peripheral request a synchronous one.
// - Address valid is active low so floating buses never select a peripheral.
// - An acknowledge cycle ended by a peripheral request is a peripheral read and yields an autovector.
// - Seven autovectors, levels one to seven, are vector numbers 25 to 31.
`timescale 1ns/1ps
module pcr_bus_engine
   import pcr_pkg::*;
(
   // Processor clock, reset and enable
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   // Clock of the peripheral select logic
   input wire logic link_clk,
   // Request from the processor core
   input wire logic req_valid,
   input wire pcr_req_t req,
   // Answer to the processor core
   output logic req_taken,
   output logic rsp_done,
   output logic rsp_sync,
   output logic rsp_fault,
   output logic [PCR_DATA_W-1:0] rsp_rdata,
   output logic rsp_vector_valid,
   output logic [7:0] rsp_vector,
   // Bus control pins
   output logic address_strobe_n,
   output logic [1:0] data_strobe_pair_n,
   output logic read_not_write,
   output logic peripheral_address_valid_out_n,
   output logic peripheral_enable_clock,
   // Address and data pins
   output logic [PCR_ADDR_W-1:0] addr_out,
   output logic addr_oe,
   output logic [PCR_DATA_W-1:0] data_out,
   output logic data_oe,
   // Pins from the peripheral side
   input wire pcr_pins_t pins_in
);

   // ==========================================================
   // Helper functions
   // Autovector number for an interrupt level
   function automatic logic [7:0] pcr_autovec(input logic [2:0] level);
      pcr_autovec = PCR_AUTOVEC_BASE + {5'h00, level};
   endfunction : pcr_autovec

   // A low active control is seen when its synchronised level is low
   function automatic logic pcr_seen(input logic level_n);
      pcr_seen = ~level_n;
   endfunction : pcr_seen

   // ==========================================================
   // Crossing of the peripheral side pins
   pcr_pins_t pins_link;
   pcr_pins_t pins_cross;
   logic [PCR_PINS_W-1:0] pins_sync_bits;
   pcr_pins_t pins_s;

   pcr_link_front u_link_front (
      .link_clk(link_clk),
      .resetn(resetn),
      .pins_in(pins_in),
      .pins_link(pins_link)
   );

   // Controls pass the link register; data skips it, since the peripheral
   // drives it only in the high enable phase, shorter than a link period.
   // The latch is timed by the enable clock, so the word is stable by then.
   assign pins_cross = '{cycle_request_n: pins_link.cycle_request_n,
      ack_n: pins_link.ack_n, fault_n: pins_link.fault_n, data: pins_in.data};

   pcr_sync #(
      .WIDTH(PCR_PINS_W),
      .RESET_VALUE(PCR_PINS_IDLE)
   ) u_sync (
      .clk(clk),
      .resetn(resetn),
      .ce(ce),
      .async_in(pins_cross),
      .sync_out(pins_sync_bits)
   );

   assign pins_s = pcr_pins_t'(pins_sync_bits);

   logic vpa_seen;
   logic ack_seen;
   logic fault_seen;

   assign vpa_seen = pcr_seen(pins_s.cycle_request_n);
   assign ack_seen = pcr_seen(pins_s.ack_n);
   assign fault_seen = pcr_seen(pins_s.fault_n);

   // ==========================================================
   // Enable clock divider
   logic [3:0] e_cnt_reg;
   logic [3:0] e_cnt_next;

   assign e_cnt_next = (e_cnt_reg == 4'(PCR_E_PERIOD - 1)) ? PCR_E_CNT_RESET
                                                             : e_cnt_reg + 4'h1;

   // Free running, so the peripheral always sees a steady clock
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         e_cnt_reg <= PCR_E_CNT_RESET;
      end else if (ce) begin
         e_cnt_reg <= e_cnt_next;
      end
   end

   // Registered output; high for the last four counts of ten
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         peripheral_enable_clock <= 1'b0;
      end else if (ce) begin
         peripheral_enable_clock <= (e_cnt_next >= 4'(PCR_E_LOW_CLKS));
      end
   end

   logic e_low_now;
   assign e_low_now = (e_cnt_reg < 4'(PCR_E_LOW_CLKS));

   // ==========================================================
   // Bus state machine
   pcr_state_t state_reg;
   pcr_state_t state_next;
   logic sync_mode_reg;
   logic vma_reg;
   logic fault_reg;
   pcr_req_t cur_reg;

   // New cycle only once the last answer has drained through the crossing;
   // a stale request would otherwise turn the next cycle into a peripheral one
   logic take_now;
   assign take_now = (state_reg == PCR_IDLE) && req_valid && !vpa_seen && !ack_seen
      && !fault_seen;

   // Next state; S01, S23, S45 and S67 each stand for one clock, i.e. two half-clock bus states
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         PCR_IDLE: begin
            if (take_now) begin
               state_next = PCR_S01;
            end
         end
         PCR_S01: begin
            state_next = PCR_S23;
         end
         PCR_S23: begin
            state_next = PCR_S45;
         end
         PCR_S45: begin
            // Peripheral request first: both at once is undefined on the bus
            if (vpa_seen) begin
               state_next = PCR_SWT;
            end else if (ack_seen || fault_seen) begin
               state_next = PCR_S67;
            end else begin
               state_next = PCR_SWT;
            end
         end
         PCR_SWT: begin
            if (sync_mode_reg) begin
               // Enter the latch state so that it lines up with the last high clock
               if (vma_reg && (e_cnt_reg == PCR_E_PRE_LATCH)) begin
                  state_next = PCR_S67;
               end
            end else if (!vpa_seen && (ack_seen || fault_seen)) begin
               state_next = PCR_S67;
            end
         end
         PCR_S67: begin
            state_next = PCR_SEND;
         end
         PCR_SEND: begin
            state_next = PCR_IDLE;
         end
         default: begin
            state_next = PCR_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= PCR_IDLE;
      end else if (ce) begin
         state_reg <= state_next;
      end
   end

   // Captured request; held for the whole cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cur_reg <= '0;
      end else if (ce && take_now) begin
         cur_reg <= req;
      end
   end

   // One-cycle pulse when the core request is taken
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         req_taken <= 1'b0;
      end else if (ce) begin
         req_taken <= take_now;
      end
   end

   // Peripheral cycle mode and bus fault capture
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sync_mode_reg <= 1'b0;
         fault_reg <= 1'b0;
      end else if (ce) begin
         if (state_reg == PCR_S01) begin
            sync_mode_reg <= 1'b0;
            fault_reg <= 1'b0;
         end else if ((state_reg == PCR_S45 || state_reg == PCR_SWT) && !sync_mode_reg) begin
            if (vpa_seen) begin
               sync_mode_reg <= 1'b1;
            end else if (fault_seen && !ack_seen) begin
               fault_reg <= 1'b1;
            end
         end
      end
   end

   // ==========================================================
   // Address valid towards the peripheral, active low
   // Late recognitions are pushed to the next enable period to keep setup before the rise
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         vma_reg <= 1'b0;
      end else if (ce) begin
         if (state_reg == PCR_SWT && sync_mode_reg && !vma_reg) begin
            if (e_low_now && (e_cnt_reg <= PCR_E_LATEST_REC)) begin
               vma_reg <= 1'b1;
            end
         end else if (state_reg == PCR_SEND || state_reg == PCR_IDLE) begin
            vma_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         peripheral_address_valid_out_n <= 1'b1;
      end else if (ce) begin
         peripheral_address_valid_out_n <= ~((state_reg == PCR_SWT && sync_mode_reg && !vma_reg
            && e_low_now && (e_cnt_reg <= PCR_E_LATEST_REC))
            || (vma_reg && state_reg != PCR_SEND));
      end
   end

   // ==========================================================
   // Strobes, address and direction
   // Strobes rise on the edge that ends the latch state; in a peripheral cycle that is the enable clock fall
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         address_strobe_n <= 1'b1;
         data_strobe_pair_n <= 2'h3;
      end else if (ce) begin
         case (state_next)
            PCR_S23, PCR_S45, PCR_SWT, PCR_S67: begin
               address_strobe_n <= 1'b0;
               data_strobe_pair_n <= ~cur_reg.strobes;
            end
            default: begin
               address_strobe_n <= 1'b1;
               data_strobe_pair_n <= 2'h3;
            end
         endcase
      end
   end

   // Address floats and read/write returns high one state after the strobes
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         addr_out <= '0;
         addr_oe <= 1'b0;
         read_not_write <= 1'b1;
      end else if (ce) begin
         if (take_now) begin
            addr_out <= req.addr;
            addr_oe <= 1'b1;
            read_not_write <= 1'b1;
         end else if (state_reg == PCR_S01) begin
            read_not_write <= ~cur_reg.write;
         end else if (state_reg == PCR_SEND) begin
            addr_oe <= 1'b0;
            read_not_write <= 1'b1;
         end
      end
   end

   // Write data driven from state three until the address floats
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         data_out <= PCR_DATA_RESET;
         data_oe <= 1'b0;
      end else if (ce) begin
         if (state_reg == PCR_S01 && cur_reg.write) begin
            data_out <= cur_reg.wdata;
            data_oe <= 1'b1;
         end else if (state_reg == PCR_SEND) begin
            data_oe <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Read data latch and answer to the core
   // Data is held stable by the peripheral through the high enable phase
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rsp_rdata <= PCR_DATA_RESET;
      end else if (ce && state_reg == PCR_S67 && !cur_reg.write) begin
         rsp_rdata <= pins_s.data;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rsp_done <= 1'b0;
         rsp_sync <= 1'b0;
         rsp_fault <= 1'b0;
      end else if (ce) begin
         rsp_done <= (state_reg == PCR_SEND);
         if (state_reg == PCR_SEND) begin
            rsp_sync <= sync_mode_reg;
            rsp_fault <= fault_reg;
         end
      end
   end

   // Autovector for an acknowledge cycle ended as a peripheral read
   // Levels outside one to seven give no vector
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rsp_vector_valid <= 1'b0;
         rsp_vector <= 8'h00;
      end else if (ce) begin
         if (state_reg == PCR_SEND) begin
            rsp_vector_valid <= cur_reg.iack && sync_mode_reg && !cur_reg.write
               && (cur_reg.level != 3'h0) && (cur_reg.level <= PCR_LEVEL_NMI);
            rsp_vector <= pcr_autovec(cur_reg.level);
         end else if (take_now) begin
            rsp_vector_valid <= 1'b0;
         end
      end
   end

endmodule : pcr_bus_engine

// File: testbench/pcr_bus_engine_asserts.sv
// Checker: timing relations at the pins of the bus engine
`timescale 1ns/1ps
module pcr_bus_engine_asserts (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Watched outputs
   input wire logic address_strobe_n,
   input wire logic read_not_write,
   input wire logic peripheral_address_valid_out_n,
   input wire logic peripheral_enable_clock,
   input wire logic addr_oe,
   input wire logic req_taken,
   input wire logic rsp_done,
   input wire logic rsp_vector_valid,
   input wire logic [7:0] rsp_vector
);
   // ==========================================================
   // Short aliases
   logic e;
   logic vld_n;
   assign e = peripheral_enable_clock;
   assign vld_n = peripheral_address_valid_out_n;

   // ==========================================================
   // Properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_e_high;
      $rose(e) ##1 e[*3];
   endsequence
   sequence s_float;
      read_not_write && !addr_oe;
   endsequence
   AST_E_LOW: assert property ($fell(e) |-> !e[*6] ##1 e)
      else $error("enable clock low phase wrong");
   AST_E_HIGH: assert property ($rose(e) |-> e[*4] ##1 !e)
      else $error("enable clock high phase wrong");
   AST_VALID_E_LOW: assert property ($fell(vld_n) |-> !e)
      else $error("address valid asserted with enable high");
   AST_VALID_TO_E: assert property ($fell(vld_n) |-> ##[1:6] s_e_high)
      else $error("enable high phase not reached after address valid");
   AST_VALID_IN_CYCLE: assert property ($fell(vld_n) |-> !address_strobe_n)
      else $error("address valid outside a bus cycle");
   AST_STROBE_E: assert property ($rose(address_strobe_n) && !$past(vld_n) |-> $fell(e))
      else $error("strobes and enable fall not together");
   AST_FLOAT: assert property ($rose(address_strobe_n) |=> s_float)
      else $error("bus not released after strobes");
   AST_VECTOR: assert property (rsp_vector_valid |-> rsp_vector inside {[8'h19:8'h1F]})
      else $error("autovector out of range");
   AST_DONE_PULSE: assert property (rsp_done |=> !rsp_done)
      else $error("done longer than one cycle");
   AST_TAKE_DONE: assert property (req_taken |-> ##[4:200] rsp_done)
      else $error("cycle never terminated");
endmodule : pcr_bus_engine_asserts

bind pcr_bus_engine pcr_bus_engine_asserts u_chk (.clk(clk), .resetn(resetn),
   .address_strobe_n(address_strobe_n), .read_not_write(read_not_write),
   .peripheral_address_valid_out_n(peripheral_address_valid_out_n),
   .peripheral_enable_clock(peripheral_enable_clock), .addr_oe(addr_oe),
   .req_taken(req_taken), .rsp_done(rsp_done), .rsp_vector_valid(rsp_vector_valid),
   .rsp_vector(rsp_vector));

// File: testbench/pcr_periph.sv
// Partner model: peripheral chip and its select logic
`timescale 1ns/1ps
module pcr_periph
   import pcr_pkg::*;
(
   // Clock, reset and behaviour
   input wire logic clk,
   input wire logic resetn,
   input wire logic [1:0] mode,
   input wire logic [3:0] dly,
   // Bus pins from the engine
   input wire logic address_strobe_n,
   input wire logic peripheral_address_valid_out_n,
   input wire logic peripheral_enable_clock,
   input wire logic read_not_write,
   input wire logic [15:0] data_out,
   // Answer pins and observed write
   output pcr_pins_t pins_in,
   output logic [15:0] wr_seen
);
   localparam logic [15:0] RD = 16'hC35A;
   logic [3:0] cnt;
   logic [15:0] last;
   logic go;
   logic drv;
   logic sel;

   // Response delay counted from address strobe
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) cnt <= 4'h0;
      else if (address_strobe_n) cnt <= 4'h0;
      else if (cnt != 4'hF) cnt <= cnt + 4'h1;
   end
   // Selected only while address valid and enable high
   assign sel = !peripheral_address_valid_out_n && peripheral_enable_clock;
   // Answer drops as soon as the strobe rises
   assign go = !address_strobe_n && cnt >= dly;
   assign drv = read_not_write && (mode == 2'h1 ? sel : (mode == 2'h0 && go));
   // At most one kind of answer at a time
   always_comb begin
      pins_in.cycle_request_n = !(go && mode == 2'h1);
      pins_in.ack_n = !(go && mode == 2'h0);
      pins_in.fault_n = !(go && mode == 2'h2);
      pins_in.data = drv ? RD : ~last;
   end
   // Released bus shows the inverse of the last value, not a stale copy
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) last <= 16'h0000;
      else last <= pins_in.data;
   end
   // Write data taken in the enable high phase
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) wr_seen <= 16'h0000;
      else if (sel && !read_not_write) wr_seen <= data_out;
   end
endmodule : pcr_periph

// File: testbench/pcr_bus_engine_tb.sv
// Testbench: peripheral, asynchronous, fault and autovector cycles
`timescale 1ns/1ps
module pcr_bus_engine_tb;
   import pcr_pkg::*;
   logic clk = 1'b0;
   logic link_clk = 1'b0;
   logic resetn = 1'b0;
   logic ce = 1'b1;
   logic req_valid = 1'b0;
   pcr_req_t req = '0;
   pcr_pins_t pins_in;
   logic [1:0] mode = 2'h0;
   logic [3:0] dly = 4'h0;
   logic req_taken, rsp_done, rsp_sync, rsp_fault, rsp_vector_valid;
   logic [15:0] rsp_rdata, data_out, wr_seen;
   logic [7:0] rsp_vector;
   logic address_strobe_n, read_not_write, peripheral_address_valid_out_n;
   logic peripheral_enable_clock, addr_oe, data_oe;
   logic [1:0] data_strobe_pair_n;
   logic [22:0] addr_out;
   int error_cnt = 0;
   int cmp_count = 0;

   // ==========================================================
   // Clocks, link clock with its own period
   always #5 clk = ~clk;
   always #80 link_clk = ~link_clk;

   pcr_bus_engine dut (.clk(clk), .resetn(resetn), .ce(ce), .link_clk(link_clk),
      .req_valid(req_valid), .req(req), .req_taken(req_taken), .rsp_done(rsp_done),
      .rsp_sync(rsp_sync), .rsp_fault(rsp_fault), .rsp_rdata(rsp_rdata),
      .rsp_vector_valid(rsp_vector_valid), .rsp_vector(rsp_vector),
      .address_strobe_n(address_strobe_n), .data_strobe_pair_n(data_strobe_pair_n),
      .read_not_write(read_not_write),
      .peripheral_address_valid_out_n(peripheral_address_valid_out_n),
      .peripheral_enable_clock(peripheral_enable_clock), .addr_out(addr_out),
      .addr_oe(addr_oe), .data_out(data_out), .data_oe(data_oe), .pins_in(pins_in));

   pcr_periph u_per (.clk(clk), .resetn(resetn), .mode(mode), .dly(dly),
      .address_strobe_n(address_strobe_n),
      .peripheral_address_valid_out_n(peripheral_address_valid_out_n),
      .peripheral_enable_clock(peripheral_enable_clock), .read_not_write(read_not_write),
      .data_out(data_out), .pins_in(pins_in), .wr_seen(wr_seen));

   // ==========================================================
   // Shared tasks
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task results;
      if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : results

   task tmo;
      error_cnt++;
      results();
   endtask : tmo

   // One core request, held until taken, then wait for the end of the cycle
   task automatic run(input logic wr, input logic ia, input logic [2:0] lv,
                      input logic [15:0] wd);
      int n;
      req = '{write: wr, iack: ia, level: lv, addr: 23'h01F2A4, wdata: wd, strobes: 2'h3};
      req_valid = 1'b1;
      n = 0;
      while (req_taken !== 1'b1) begin
         @(posedge clk);
         #1;
         n++;
         if (n > 50) tmo();
      end
      req_valid = 1'b0;
      n = 0;
      while (rsp_done !== 1'b1) begin
         @(posedge clk);
         #1;
         n++;
         if (n > 300) tmo();
      end
   endtask : run

   // ==========================================================
   // Scenarios
   task t_async;
      mode = 2'h0;
      dly = 4'h6;
      run(1'b0, 1'b0, 3'h0, 16'h0000);
      chk(16'(rsp_sync), 16'h0000);
      chk(rsp_rdata, 16'hC35A);
   endtask : t_async

   // Peripheral requests at delays of 0 to 9 clocks after the address strobe
   task t_prd;
      for (int d = 0; d < 10; d++) begin
         mode = 2'h1;
         dly = 4'(d);
         run(1'b0, 1'b0, 3'h0, 16'h0000);
         chk(16'(rsp_sync), 16'h0001);
         chk(rsp_rdata, 16'hC35A);
      end
   endtask : t_prd

   task t_pwr;
      mode = 2'h1;
      dly = 4'h0;
      run(1'b1, 1'b0, 3'h0, 16'h3CA5);
      chk(wr_seen, 16'h3CA5);
      chk(16'({addr_oe, data_oe, data_strobe_pair_n}), 16'h0003);
      chk(addr_out[15:0], 16'hF2A4);
      chk(16'(rsp_sync), 16'h0001);
   endtask : t_pwr

   task t_vec;
      mode = 2'h1;
      for (int lv = 1; lv < 8; lv++) begin
         run(1'b0, 1'b1, 3'(lv), 16'h0000);
         chk(16'(rsp_vector_valid), 16'h0001);
         chk(16'(rsp_vector), 16'h0018 + 16'(lv));
      end
   endtask : t_vec

   task t_fault;
      mode = 2'h2;
      dly = 4'h2;
      run(1'b0, 1'b0, 3'h0, 16'h0000);
      chk(16'(rsp_fault), 16'h0001);
   endtask : t_fault

   // ==========================================================
   // Main sequence; reset also spans two link clock edges
   initial begin
      repeat (4) @(posedge clk);
      repeat (2) @(posedge link_clk);
      chk(16'({address_strobe_n, peripheral_address_valid_out_n,
               peripheral_enable_clock, addr_oe}), 16'h000C);
      @(posedge clk);
      #1;
      resetn = 1'b1;
      t_async();
      t_prd();
      t_pwr();
      t_vec();
      t_fault();
      results();
   end
endmodule : pcr_bus_engine_tb
